// ===== hdl/clkout_pkg.sv
/*
 * Shared definitions for one clock output channel: register offsets,
 * register layouts as packed structs, reset values, driver type and
 * parked-state codes.
 * Assumes a register port with byte addresses and 16-bit data words.
 */
package clkout_pkg;

   // ==========================================================
   // widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned RATIO_W = 14;

   // ==========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] DIV_CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] DRV_EN_OFS = 8'h02;
   localparam logic [ADDR_W-1:0] DRV_TYPE_OFS = 8'h03;

   // ==========================================================
   // output divider control, 16 bits
   typedef struct packed {
      logic divider_regulator_on;
      logic rsvd;
      logic [RATIO_W-1:0] ratio;
   } div_ctrl_t;

   // output driver enable, 8 bits
   typedef struct packed {
      logic [3:0] rsvd;
      logic [1:0] park_state;
      logic force_off;
      logic driver_power_down;
   } drv_en_t;

   // output driver type configuration, 8 bits
   typedef struct packed {
      logic [1:0] se_phase;
      logic [1:0] diff_common_level;
      logic term_on;
      logic bias_on;
      logic [1:0] drv_type;
   } drv_type_t;

   // ==========================================================
   // reset values
   localparam logic [RATIO_W-1:0] RATIO_RST = 14'h0069;
   localparam div_ctrl_t DIV_CTRL_RST = '{divider_regulator_on: 1'b1, rsvd: 1'b0, ratio: RATIO_RST};
   localparam drv_en_t DRV_EN_RST = '{rsvd: 4'h0, park_state: 2'h0, force_off: 1'b0, driver_power_down: 1'b0};
   localparam drv_type_t DRV_TYPE_RST = '{se_phase: 2'h1, diff_common_level: 2'h2, term_on: 1'b1,
                                          bias_on: 1'b1, drv_type: 2'h0};

   // ==========================================================
   // codes
   typedef enum logic [1:0] {
      TYPE_CML = 2'h0,
      TYPE_RSVD = 2'h1,
      TYPE_LVDS = 2'h2,
      TYPE_SE = 2'h3
   } drv_kind_t;

   typedef enum logic [1:0] {
      PARK_LOW_LOW = 2'h0,
      PARK_LOW_HIGH = 2'h1,
      PARK_HIGH_Z = 2'h2,
      PARK_RUNNING = 2'h3
   } park_t;

   typedef enum logic [1:0] {
      SE_IN_PHASE = 2'h0,
      SE_OPPOSITE = 2'h1,
      SE_TRUE_ONLY = 2'h2,
      SE_COMP_ONLY = 2'h3
   } se_phase_t;

   // pin pair: levels and enables
   typedef struct packed {
      logic true_lvl;
      logic comp_lvl;
      logic true_oe;
      logic comp_oe;
   } pin_pair_t;

endpackage

// ===== hdl/clkout_divider.sv
/*
 * Output divider: divides the system clock by a programmable ratio and
 * marks the start of each low phase.
 * Assumes a ratio of two or more; the caller passes the register ratio field in unchecked.
 */
`timescale 1ns/10ps
module clkout_divider #(
   parameter int unsigned WIDTH = 14
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   input wire logic [WIDTH-1:0] ratio_in,
   output logic level_out,
   output logic fall_out
);

   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic level_q, level_d;
   logic fall_q, fall_d;
   logic [WIDTH-1:0] half;

   // ==========================================================
   // count through one period, high for the first half
   always_comb begin
      half = ratio_in >> 1;
      if (!run_in) begin
         cnt_d = '0;
         level_d = 1'b0; // regulator off stops the divider low
      end else begin
         if (cnt_q >= ratio_in - 1'b1) begin
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
         level_d = (cnt_d < half);
      end
      fall_d = level_q & ~level_d;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         level_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
         fall_q <= fall_d;
      end
   end

   assign level_out = level_q;
   assign fall_out = fall_q;

endmodule

// ===== hdl/clock_output_channel.sv
/*
 * One clock output channel: divider control, driver enable and driver
 * type registers, output enable pin handling and the output pin pair.
 * Assumes the serial processor port logic drives the register port on
 * the system clock; the enable pin comes from outside and is synchronised.
 */
// How it works
// - divide ratio field resets to 0x69.
// - bit 15 of divider control turns divider regulator on, resets one.
// - parked state bits 3:2 choose low/low (low/high when type is low-voltage differential), low/high, high-z or running.
// - force-off bit 1 disables driver whatever else enables it.
// - driver enabled only when no disable source is active, sources ORed.
// - power-down bit 0 tri-states both pins and ignores output enable.
// - single-ended phase bits 7:6 pick in-phase, opposite, true or complement.
// - type bits 1:0 pick current-mode, low-voltage differential or single-ended.
// - bits 5:4 choose one of four differential common levels, reset two.
// - bit 3 enables internal termination, reset one.
// - bit 2 enables driver bias circuit, reset one.
`timescale 1ns/10ps
module clock_output_channel
   import clkout_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // register port
   input wire logic [clkout_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [clkout_pkg::DATA_W-1:0] REG_WDATA_IN,
   output logic [clkout_pkg::DATA_W-1:0] REG_RDATA_OUT,
   // output enable pin, high enables
   input wire logic OUT_ENABLE_IN,
   // clock pin pair
   output logic CLOCK_OUT_TRUE_OUT,
   output logic CLOCK_OUT_TRUE_OE_OUT,
   output logic CLOCK_OUT_COMPLEMENT_OUT,
   output logic CLOCK_OUT_COMPLEMENT_OE_OUT,
   // analog controls
   output logic DIVIDER_REGULATOR_ON_OUT,
   output logic BIAS_ON_OUT,
   output logic TERM_ON_OUT,
   output logic [1:0] DIFF_COMMON_LEVEL_OUT,
   output logic [1:0] DRV_TYPE_OUT
);
   import clkout_pkg::*;

   // ==========================================================
   // register file
   div_ctrl_t div_ctrl_q, div_ctrl_d;
   drv_en_t drv_en_q, drv_en_d;
   drv_type_t drv_type_q, drv_type_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;

   // writes store fields, reserved bits stay zero; reads answer next cycle
   always_comb begin
      div_ctrl_d = div_ctrl_q;
      drv_en_d = drv_en_q;
      drv_type_d = drv_type_q;
      rdata_d = rdata_q;
      if (REG_WR_IN) begin
         case (REG_ADDR_IN)
            DIV_CTRL_OFS: begin
               div_ctrl_d = div_ctrl_t'(REG_WDATA_IN);
               div_ctrl_d.rsvd = 1'b0;
            end
            DRV_EN_OFS: begin
               drv_en_d = drv_en_t'(REG_WDATA_IN[7:0]);
               drv_en_d.rsvd = '0;
            end
            DRV_TYPE_OFS: begin
               drv_type_d = drv_type_t'(REG_WDATA_IN[7:0]);
            end
            default: begin
            end
         endcase
      end
      if (REG_RD_IN) begin
         case (REG_ADDR_IN)
            DIV_CTRL_OFS: rdata_d = div_ctrl_q;
            DRV_EN_OFS: rdata_d = {8'h00, drv_en_q};
            DRV_TYPE_OFS: rdata_d = {8'h00, drv_type_q};
            default: rdata_d = '0; // unmapped reads return zero
         endcase
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         div_ctrl_q <= DIV_CTRL_RST;
         drv_en_q <= DRV_EN_RST;
         drv_type_q <= DRV_TYPE_RST;
         rdata_q <= '0;
      end else begin
         div_ctrl_q <= div_ctrl_d;
         drv_en_q <= drv_en_d;
         drv_type_q <= drv_type_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // output divider, stopped while its regulator is off
   logic div_level;
   logic div_fall;

   clkout_divider #(
      .WIDTH(RATIO_W)
   ) u_divider (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .run_in(div_ctrl_q.divider_regulator_on),
      .ratio_in(div_ctrl_q.ratio),
      .level_out(div_level),
      .fall_out(div_fall)
   );

   // ==========================================================
   // output enable pin: three stages, change accepted when two agree
   logic oe_s1_q, oe_s2_q, oe_s3_q, oe_stable_q;
   logic oe_stable_d;

   always_comb begin
      oe_stable_d = oe_stable_q;
      if (oe_s2_q == oe_s3_q) begin
         oe_stable_d = oe_s3_q;
      end
   end

   // reset to enabled so the pin's pull-up default is not glitched
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         oe_s1_q <= 1'b1;
         oe_s2_q <= 1'b1;
         oe_s3_q <= 1'b1;
         oe_stable_q <= 1'b1;
      end else begin
         oe_s1_q <= OUT_ENABLE_IN;
         oe_s2_q <= oe_s1_q;
         oe_s3_q <= oe_s2_q;
         oe_stable_q <= oe_stable_d;
      end
   end

   // ==========================================================
   // enable decision, applied at the start of a low phase, or at once while the divider is stopped
   logic drv_on_q, drv_on_d;
   logic [1:0] park_q, park_d;
   logic want_on;

   always_comb begin
      want_on = ~(drv_en_q.force_off | ~oe_stable_q);
      drv_on_d = drv_on_q;
      park_d = park_q;
      // a stopped divider has no pulse to shorten, so apply at once
      if (div_fall || !div_ctrl_q.divider_regulator_on) begin
         drv_on_d = want_on;
         park_d = drv_en_q.park_state;
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         drv_on_q <= 1'b1;
         park_q <= PARK_LOW_LOW;
      end else begin
         drv_on_q <= drv_on_d;
         park_q <= park_d;
      end
   end

   // ==========================================================
   // pin pair from type, phase, park state and power-down
   pin_pair_t pins_q, pins_d;
   logic running;

   always_comb begin
      running = drv_on_q || (park_q == PARK_RUNNING);
      pins_d = '{true_lvl: 1'b0, comp_lvl: 1'b0, true_oe: 1'b1, comp_oe: 1'b1};
      if (drv_en_q.driver_power_down) begin
         pins_d.true_oe = 1'b0;
         pins_d.comp_oe = 1'b0;
      end else if (running) begin
         if (drv_type_q.drv_type == TYPE_SE) begin
            case (drv_type_q.se_phase)
               SE_IN_PHASE: begin
                  pins_d.true_lvl = div_level;
                  pins_d.comp_lvl = div_level;
               end
               SE_OPPOSITE: begin
                  pins_d.true_lvl = div_level;
                  pins_d.comp_lvl = ~div_level;
               end
               SE_TRUE_ONLY: begin
                  pins_d.true_lvl = div_level;
               end
               default: begin
                  pins_d.comp_lvl = ~div_level;
               end
            endcase
         end else begin
            pins_d.true_lvl = div_level;
            pins_d.comp_lvl = ~div_level;
         end
      end else begin
         case (park_q)
            PARK_LOW_LOW: begin
               pins_d.comp_lvl = (drv_type_q.drv_type == TYPE_LVDS);
            end
            PARK_LOW_HIGH: begin
               pins_d.comp_lvl = 1'b1;
            end
            default: begin
               pins_d.true_oe = 1'b0;
               pins_d.comp_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         pins_q <= '{true_lvl: 1'b0, comp_lvl: 1'b0, true_oe: 1'b0, comp_oe: 1'b0};
      end else begin
         pins_q <= pins_d;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   assign REG_RDATA_OUT = rdata_q;
   assign CLOCK_OUT_TRUE_OUT = pins_q.true_lvl;
   assign CLOCK_OUT_TRUE_OE_OUT = pins_q.true_oe;
   assign CLOCK_OUT_COMPLEMENT_OUT = pins_q.comp_lvl;
   assign CLOCK_OUT_COMPLEMENT_OE_OUT = pins_q.comp_oe;
   assign DIVIDER_REGULATOR_ON_OUT = div_ctrl_q.divider_regulator_on;
   assign BIAS_ON_OUT = drv_type_q.bias_on;
   assign TERM_ON_OUT = drv_type_q.term_on;
   assign DIFF_COMMON_LEVEL_OUT = drv_type_q.diff_common_level;
   assign DRV_TYPE_OUT = drv_type_q.drv_type;

endmodule

// ===== verification/clkout_sva.sv
/* checker for one clock output channel, watching top ports only
   assumes one clock domain and the register offsets of the package */
`timescale 1ns/10ps
module clkout_sva (
   // clock, reset, register port
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [clkout_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [clkout_pkg::DATA_W-1:0] REG_WDATA_IN,
   input wire logic [clkout_pkg::DATA_W-1:0] REG_RDATA_OUT,
   // pins and levels
   input wire logic CLOCK_OUT_TRUE_OE_OUT,
   input wire logic CLOCK_OUT_COMPLEMENT_OE_OUT,
   input wire logic DIVIDER_REGULATOR_ON_OUT,
   input wire logic [1:0] DIFF_COMMON_LEVEL_OUT,
   input wire logic [1:0] DRV_TYPE_OUT
);
   import clkout_pkg::*;
   // ====
   // shadows
   logic [3:0] en_q, en_d;
   logic [13:0] rat_q, rat_d;
   logic [14:0] cnt_q, cnt_d;
   wire wr_div = REG_WR_IN && REG_ADDR_IN == DIV_CTRL_OFS;
   wire wr_en = REG_WR_IN && REG_ADDR_IN == DRV_EN_OFS;
   wire wr_typ = REG_WR_IN && REG_ADDR_IN == DRV_TYPE_OFS;
   wire oe_off = !CLOCK_OUT_TRUE_OE_OUT && !CLOCK_OUT_COMPLEMENT_OE_OUT;
   // park timer saturates so a long park never wraps
   always_comb begin
      en_d = wr_en ? REG_WDATA_IN[3:0] : en_q;
      rat_d = wr_div ? REG_WDATA_IN[13:0] : rat_q;
      cnt_d = (en_q == 4'ha) ? cnt_q + {14'h0000, ~&cnt_q} : 15'h0000;
   end
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         en_q <= 4'h0;
         rat_q <= RATIO_RST;
         cnt_q <= 15'h0000;
      end else begin
         en_q <= en_d;
         rat_q <= rat_d;
         cnt_q <= cnt_d;
      end
   end
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // ====
   // properties
   a_pd_tristate: assert property (wr_en && REG_WDATA_IN[0] |-> ##[1:3] oe_off)
      else $error("pins driven after power down");
   a_pd_holds: assert property (en_q[0] && $past(en_q[0], 3) |-> oe_off)
      else $error("pins driven while powered down");
   a_oe_together: assert property (CLOCK_OUT_TRUE_OE_OUT == CLOCK_OUT_COMPLEMENT_OE_OUT)
      else $error("pin enables differ");
   a_reg_level: assert property (wr_div |=> DIVIDER_REGULATOR_ON_OUT == $past(REG_WDATA_IN[15]))
      else $error("regulator level wrong");
   a_type_levels: assert property (wr_typ |=> {DIFF_COMMON_LEVEL_OUT, DRV_TYPE_OUT} ==
      {$past(REG_WDATA_IN[5:4]), $past(REG_WDATA_IN[1:0])}) else $error("type levels wrong");
   a_div_readback: assert property (REG_RD_IN && REG_ADDR_IN == DIV_CTRL_OFS |=>
      REG_RDATA_OUT[15:14] == {$past(DIVIDER_REGULATOR_ON_OUT), 1'b0}) else $error("divider read wrong");
   a_type_readback: assert property (REG_RD_IN && REG_ADDR_IN == DRV_TYPE_OFS |=>
      DRV_TYPE_OUT == REG_RDATA_OUT[1:0] || $past(wr_typ)) else $error("type read wrong");
   a_park_hiz: assert property (cnt_q > {1'b0, rat_q} + 15'd3 |-> oe_off)
      else $error("parked pins still driven");
   // main scenarios
   c_park: cover property (cnt_q > 15'd20);
   c_single: cover property (DRV_TYPE_OUT == 2'h3 && CLOCK_OUT_TRUE_OE_OUT);
   c_pd: cover property (en_q[0] && oe_off);
endmodule
bind clock_output_channel clkout_sva clkout_sva_i (.REF_CLK_IN, .RST_N_IN, .REG_ADDR_IN, .REG_WR_IN,
   .REG_RD_IN, .REG_WDATA_IN, .REG_RDATA_OUT, .CLOCK_OUT_TRUE_OE_OUT, .CLOCK_OUT_COMPLEMENT_OE_OUT,
   .DIVIDER_REGULATOR_ON_OUT, .DIFF_COMMON_LEVEL_OUT, .DRV_TYPE_OUT);

// ===== verification/clkin_sink.sv
/* far-side clock receiver: resolves the pin pair, counts true rising edges
   assumes termination to ground pulls an undriven pin low */
`timescale 1ns/10ps
module clkin_sink (
   // pins
   input wire logic true_in,
   input wire logic true_oe_in,
   input wire logic comp_in,
   input wire logic comp_oe_in,
   // control and results
   input wire logic clear_in,
   output logic true_lvl_out,
   output logic comp_lvl_out,
   output int unsigned edges_out
);
   // ====
   // released pins sink to ground, never keep the last level
   assign true_lvl_out = true_oe_in && true_in;
   assign comp_lvl_out = comp_oe_in && comp_in;
   always @(posedge true_lvl_out or posedge clear_in) begin
      edges_out <= clear_in ? 0 : edges_out + 1;
   end
endmodule

// ===== verification/tb_top.sv
/* bench for clock_output_channel with a receiver model on its pins
   assumes a 200 MHz clock; inputs change on the falling edge */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t got %h want %h", $time, g, e); end end
module tb_top;
   import clkout_pkg::*;
   // ====
   // stimulus and observed signals
   logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, oe_pin = 1, clr = 1, bad;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, d;
   logic t, c, t_oe, c_oe, reg_on, bias, term, tl, cl;
   logic [1:0] cm, typ;
   int unsigned edges;
   int failures = 0, cmp_count = 0;
   typedef struct packed {logic [7:0] a; logic w; logic [15:0] wd; logic [15:0] rb;} row_t;
   // address, write flag, write data, readback
   row_t rows [7] = '{'{8'h00, 1'b0, 16'h0000, 16'h8069}, '{8'h02, 1'b0, 16'h0000, 16'h0000},
      '{8'h03, 1'b0, 16'h0000, 16'h006c}, '{8'h01, 1'b1, 16'hffff, 16'h0000},
      '{8'h00, 1'b1, 16'hc00a, 16'h800a}, '{8'h02, 1'b1, 16'hfff8, 16'h0008},
      '{8'h03, 1'b1, 16'hffd1, 16'h00d1}};
   logic [3:0] park_exp [3] = '{4'h3, 4'h7, 4'h0};
   clock_output_channel clock_output_channel_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
      .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
      .OUT_ENABLE_IN(oe_pin), .CLOCK_OUT_TRUE_OUT(t), .CLOCK_OUT_TRUE_OE_OUT(t_oe),
      .CLOCK_OUT_COMPLEMENT_OUT(c), .CLOCK_OUT_COMPLEMENT_OE_OUT(c_oe), .DIVIDER_REGULATOR_ON_OUT(reg_on),
      .BIAS_ON_OUT(bias), .TERM_ON_OUT(term), .DIFF_COMMON_LEVEL_OUT(cm), .DRV_TYPE_OUT(typ));
   clkin_sink clkin_sink_i (.true_in(t), .true_oe_in(t_oe), .comp_in(c), .comp_oe_in(c_oe),
      .clear_in(clr), .true_lvl_out(tl), .comp_lvl_out(cl), .edges_out(edges));
   // 5 ns clock
   always #2.5 clk = ~clk;
   // one-cycle strobes; a falling edge passes between accesses
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(negedge clk);
      addr = a;
      wdata = v;
      wr_s = 1;
      @(negedge clk);
      wr_s = 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(negedge clk);
      addr = a;
      rd_s = 1;
      @(negedge clk);
      rd_s = 0;
      v = rdata;
   endtask
   // edges over a whole number of periods, so phase does not matter
   task automatic count(input int unsigned n, input int unsigned e);
      clr = 1;
      @(negedge clk);
      clr = 0;
      repeat (n) @(negedge clk);
      `CHK(edges, e)
   endtask
   task automatic final_report;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (2) @(negedge clk);
      `CHK({t_oe, c_oe, reg_on, bias, term, cm, typ}, 9'h078)
      rst_n = 1;
      repeat (20) @(negedge clk);
      count(1050, 10);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].wd);
         rd(rows[i].a, d);
         `CHK(d, rows[i].rb)
      end
      // last row cleared bias and termination and moved the common level
      `CHK({bias, term, cm, typ}, 6'h05)
      for (int m = 0; m < 4; m++) begin
         wr(DRV_TYPE_OFS, {8'h00, m[1:0], 6'h2f});
         repeat (12) @(negedge clk);
         bad = 0;
         repeat (20) begin
            @(negedge clk);
            bad |= (m == 0) ? t !== c : (m == 1) ? t === c : (m == 2) ? c !== 1'b0 : t !== 1'b0;
         end
         `CHK(bad, 1'b0)
      end
      wr(DRV_TYPE_OFS, 16'h002c);
      // force-off written early in a high phase must not cut that pulse short
      @(posedge t);
      wr(DRV_EN_OFS, 16'h0002);
      repeat (2) @(negedge clk);
      `CHK(t, 1'b1)
      for (int p = 0; p < 4; p++) begin
         wr(DRV_EN_OFS, {12'h000, p[1:0], 2'b10});
         repeat (30) @(negedge clk);
         if (p < 3) `CHK({tl, cl, t_oe, c_oe}, park_exp[p])
         else count(100, 10);
      end
      wr(DRV_TYPE_OFS, 16'h002a);
      wr(DRV_EN_OFS, 16'h0002);
      repeat (30) @(negedge clk);
      `CHK({tl, cl, t_oe, c_oe}, 4'h7)
      wr(DRV_EN_OFS, 16'h0004);
      oe_pin = 0;
      repeat (30) @(negedge clk);
      `CHK({tl, cl, t_oe, c_oe}, 4'h7)
      count(100, 0);
      oe_pin = 1;
      wr(DRV_EN_OFS, 16'h0001);
      repeat (2) @(negedge clk);
      `CHK({t_oe, c_oe}, 2'b00)
      oe_pin = 0;
      repeat (10) @(negedge clk);
      oe_pin = 1;
      count(100, 0);
      wr(DIV_CTRL_OFS, 16'h000a);
      @(negedge clk);
      `CHK(reg_on, 1'b0)
      final_report;
   end
   // watchdog: the sequence needs about 1760 cycles
   initial begin
      #50000;
      failures++;
      final_report;
   end
endmodule
